/* hw/fce_pkg.sv */
// Constants, register map and alarm encodings of the fault code output encoder.
// Assumes a 32-bit classic Wishbone slave port and a 25 MHz clock.
package fce_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_MASK   = 8'h04;
  localparam logic [7:0] ADR_LIMIT  = 8'h08;
  localparam logic [7:0] ADR_STATE  = 8'h0c;

  // Values after reset.
  localparam logic [31:0] LIMIT_RST = 32'h0000_0400;
  localparam logic [9:0]  MASK_RST  = 10'h000;

  // Alarm and warning source positions, lower index wins a tie.
  localparam int unsigned NSRC     = 10;
  localparam logic [3:0] S_ENC_PAR = 4'h0;
  localparam logic [3:0] S_ECHO    = 4'h1;
  localparam logic [3:0] S_TURNS   = 4'h2;
  localparam logic [3:0] S_POS_ERR = 4'h3;
  localparam logic [3:0] S_OPTION  = 4'h4;
  localparam logic [3:0] S_PHASE   = 4'h5;
  localparam logic [3:0] S_OVL     = 4'h6;
  localparam logic [3:0] S_REGEN   = 4'h7;
  localparam logic [3:0] S_OVL_W   = 4'h8;
  localparam logic [3:0] S_REGEN_W = 4'h9;

  // Sources that only a power cycle clears.
  localparam logic [9:0] NONRST    = 10'h003;
  // Sources that are alarms rather than warnings.
  localparam logic [9:0] ALARMS    = 10'h0ff;

  // Output codes {a, b, c}, a set bit means the transistor conducts.
  localparam logic [2:0] CODE_ENC  = 3'h5;
  localparam logic [2:0] CODE_POS  = 3'h6;
  localparam logic [2:0] CODE_OPT  = 3'h3;
  localparam logic [2:0] CODE_PHS  = 3'h2;
  localparam logic [2:0] CODE_OVL  = 3'h7;
  localparam logic [2:0] CODE_RGN  = 3'h1;
  localparam logic [2:0] CODE_OVLW = 3'h4;
  localparam logic [2:0] CODE_RGNW = 3'h2;
  localparam logic [2:0] CODE_NONE = 3'h0;

  typedef enum logic {FCE_NORMAL, FCE_ALARM} fce_state_t;

  function automatic logic [2:0] fce_code(input logic [3:0] idx);
    logic [2:0] c;
    c = CODE_NONE;
    unique case (idx)
      S_ENC_PAR, S_ECHO, S_TURNS: c = CODE_ENC;
      S_POS_ERR: c = CODE_POS;
      S_OPTION:  c = CODE_OPT;
      S_PHASE:   c = CODE_PHS;
      S_OVL:     c = CODE_OVL;
      S_REGEN:   c = CODE_RGN;
      S_OVL_W:   c = CODE_OVLW;
      S_REGEN_W: c = CODE_RGNW;
      default:   c = CODE_NONE;
    endcase
    return c;
  endfunction

  // Index of the lowest set bit, zero when none is set.
  function automatic logic [3:0] fce_first(input logic [9:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--)
      if (v[i])
        r = 4'(i);
    return r;
  endfunction

endpackage

/* hw/fce_sync.sv */
// Three-stage input synchroniser with a two-stage agreement filter.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/1ps
module fce_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_r, s2_r, s3_r, q_r;
  logic [W-1:0] q_nxt;

  // A bit only moves once the second and third stages agree.
  always_comb
  begin
    q_nxt = (s2_r & ~(s2_r ^ s3_r)) | (q_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end
    else
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule // fce_sync

/* hw/fce_irq.sv */
// Sticky event status, interrupt mask and the level interrupt output.
// Assumes the clear mask carries exactly the bits that software has read.
`timescale 1ns/1ps
module fce_irq (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [9:0] set_i,
  input  wire logic [9:0] clr_i,
  input  wire logic       mask_we_i,
  input  wire logic [9:0] mask_wd_i,
  output logic      [9:0] status_o,
  output logic      [9:0] mask_o,
  output logic            irq_o
);

  logic [9:0] status_r, status_nxt;
  logic [9:0] mask_r, mask_nxt;
  logic       irq_r, irq_nxt;

  // A new event in the clearing cycle survives the clear.
  always_comb
  begin
    status_nxt = (status_r & ~clr_i) | set_i;
    mask_nxt   = mask_we_i ? mask_wd_i : mask_r;
    irq_nxt    = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_r <= '0;
      mask_r   <= fce_pkg::MASK_RST;
      irq_r    <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign status_o = status_r;
  assign mask_o   = mask_r;
  assign irq_o    = irq_r;

endmodule // fce_irq

/* hw/fce_encoder.sv */
// Fault code output encoder: latches the first alarm and drives the code
// and summary transistors, with a Wishbone register port and an interrupt.
// Assumes detector levels arrive asynchronously and the error count is
// produced on clk_i.
//
// What this block does
// - Outputs are transistors; summary conducts normally, released on any alarm.
// - Faulty encoder parameters latch an alarm and release the summary output.
// - Multi-turn limit mismatch shows code ON OFF ON, summary OFF.
// - Error count above the limit register shows ON ON OFF, summary OFF.
// - Option unit detection failure shows OFF ON ON, summary OFF.
// - Missing supply phase shows OFF ON OFF, summary OFF.
// - Overload warning ON OFF OFF always precedes the overload alarm.
// - Regenerative warning OFF ON OFF always precedes the regenerative alarm.
// - Fault clear is ignored for non-resettable alarms; only reset clears them.
`timescale 1ns/1ps
module fce_encoder (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cause_enc_param_i,
  input  wire logic        cause_echo_i,
  input  wire logic        cause_turn_limit_i,
  input  wire logic        cause_option_i,
  input  wire logic        cause_open_phase_i,
  input  wire logic        cause_ovl_warn_i,
  input  wire logic        cause_ovl_alarm_i,
  input  wire logic        cause_regen_warn_i,
  input  wire logic        cause_regen_alarm_i,
  input  wire logic [31:0] pos_err_count_i,
  input  wire logic        fault_clear_in_n_i,
  output logic             fault_code_bit_a_o,
  output logic             fault_code_bit_b_o,
  output logic             fault_code_bit_c_o,
  output logic             fault_summary_out_o,
  output logic             irq_o
);

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = wd[8*i +: 8];
    return r;
  endfunction

  logic [8:0] pin_q;
  logic [9:0] status, mask;

  fce_sync #(.W(9)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({~fault_clear_in_n_i, cause_regen_alarm_i, cause_regen_warn_i,
             cause_ovl_alarm_i, cause_ovl_warn_i, cause_open_phase_i,
             cause_option_i, cause_turn_limit_i, cause_echo_i}),
    .q_o   (pin_q)
  );

  // Encoder parameter fault has its own stage so it never aliases echo-back.
  logic enc_q;
  fce_sync #(.W(1)) u_sync_enc (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (cause_enc_param_i),
    .q_o   (enc_q)
  );

  logic clr_lvl, ovl_w_in, ovl_a_in, rgn_w_in, rgn_a_in;
  assign clr_lvl  = pin_q[8];
  assign rgn_a_in = pin_q[7];
  assign rgn_w_in = pin_q[6];
  assign ovl_a_in = pin_q[5];
  assign ovl_w_in = pin_q[4];

  // Alarm latch: holds the first alarm and drives the code outputs.
  fce_pkg::fce_state_t state_r, state_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic       ovl_wd_r, ovl_wd_nxt, rgn_wd_r, rgn_wd_nxt;
  logic       rgn_seen_r, rgn_seen_nxt;
  logic       clr_d_r, clr_edge;
  logic [9:0] cond, cond_d_r, alarms;
  logic [31:0] limit_r, limit_nxt;
  logic [2:0] code_r, code_nxt;
  logic       summ_r, summ_nxt;

  assign clr_edge = clr_lvl & ~clr_d_r;

  always_comb
  begin
    ovl_wd_nxt = ovl_w_in | ovl_a_in;
    rgn_wd_nxt = rgn_w_in | rgn_a_in;
    // The overload warning outranks the regen warning on the pins, so the regen
    // alarm waits until its own warning code has really been shown once.
    rgn_seen_nxt = rgn_wd_r & (rgn_seen_r | (state_r == fce_pkg::FCE_NORMAL &&
                                             code_r == fce_pkg::CODE_RGNW));
    cond = '0;
    cond[fce_pkg::S_ENC_PAR] = enc_q;
    cond[fce_pkg::S_ECHO]    = pin_q[0];
    cond[fce_pkg::S_TURNS]   = pin_q[1];
    cond[fce_pkg::S_POS_ERR] = pos_err_count_i > limit_r;
    cond[fce_pkg::S_OPTION]  = pin_q[2];
    cond[fce_pkg::S_PHASE]   = pin_q[3];
    cond[fce_pkg::S_OVL]     = ovl_a_in & ovl_wd_r;
    cond[fce_pkg::S_REGEN]   = rgn_a_in & rgn_wd_r & rgn_seen_r;
    cond[fce_pkg::S_OVL_W]   = ovl_wd_r;
    cond[fce_pkg::S_REGEN_W] = rgn_wd_r;
    alarms    = cond & fce_pkg::ALARMS;
    state_nxt = state_r;
    idx_nxt   = idx_r;
    unique case (state_r)
      fce_pkg::FCE_NORMAL:
        if (|alarms)
        begin
          state_nxt = fce_pkg::FCE_ALARM;
          idx_nxt   = fce_pkg::fce_first(alarms);
        end
      fce_pkg::FCE_ALARM:
        // A clear seen while a cause still stands is dropped; the host clears again.
        // clear ignored / clear when cause gone
        if (clr_edge && !fce_pkg::NONRST[idx_r] && !(|alarms))
          state_nxt = fce_pkg::FCE_NORMAL;
    endcase
    summ_nxt = (state_nxt == fce_pkg::FCE_NORMAL);
    if (state_nxt == fce_pkg::FCE_ALARM)
      code_nxt = fce_pkg::fce_code(idx_nxt);
    else if (ovl_wd_nxt)
      code_nxt = fce_pkg::CODE_OVLW;
    else if (rgn_wd_nxt)
      code_nxt = fce_pkg::CODE_RGNW;
    else
      code_nxt = fce_pkg::CODE_NONE;
  end

  // Wishbone slave with a one-cycle registered answer.
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [9:0]  clr_mask;
  logic        mask_we, req, wr;
  logic [31:0] mask_w;

  assign req    = wb_cyc_i & wb_stb_i;
  assign wr     = req & ack_r & wb_we_i;
  assign mask_w = wmerge({22'h0, mask}, wb_dat_i, wb_sel_i);

  always_comb
  begin
    ack_nxt   = req & ~ack_r;
    dat_nxt   = dat_r;
    limit_nxt = limit_r;
    mask_we   = 1'b0;
    clr_mask  = '0;
    if (ack_nxt)
    begin
      unique case (wb_adr_i)
        fce_pkg::ADR_STATUS: dat_nxt = {22'h0, status};
        fce_pkg::ADR_MASK:   dat_nxt = {22'h0, mask};
        fce_pkg::ADR_LIMIT:  dat_nxt = limit_r;
        fce_pkg::ADR_STATE:  dat_nxt = {23'h0, state_r == fce_pkg::FCE_ALARM,
                                        idx_r, code_r, summ_r};
        default:             dat_nxt = 32'h0;
      endcase
    end
    // Only the bits handed out are cleared, so later events stay pending.
    if (req && ack_r && !wb_we_i && wb_adr_i == fce_pkg::ADR_STATUS)
      clr_mask = dat_r[9:0];
    if (wr && wb_adr_i == fce_pkg::ADR_MASK)
      mask_we = 1'b1;
    if (wr && wb_adr_i == fce_pkg::ADR_LIMIT)
      limit_nxt = wmerge(limit_r, wb_dat_i, wb_sel_i);
  end

  fce_irq u_irq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .set_i     (cond & ~cond_d_r),
    .clr_i     (clr_mask),
    .mask_we_i (mask_we),
    .mask_wd_i (mask_w[9:0]),
    .status_o  (status),
    .mask_o    (mask),
    .irq_o     (irq_o)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r  <= fce_pkg::FCE_NORMAL;
      idx_r    <= 4'h0;
      ovl_wd_r <= 1'b0;
      rgn_wd_r <= 1'b0;
      rgn_seen_r <= 1'b0;
      clr_d_r  <= 1'b0;
      cond_d_r <= '0;
      limit_r  <= fce_pkg::LIMIT_RST;
      code_r   <= fce_pkg::CODE_NONE;
      summ_r   <= 1'b1;
      ack_r    <= 1'b0;
      dat_r    <= 32'h0;
    end
    else
    begin
      state_r  <= state_nxt;
      idx_r    <= idx_nxt;
      ovl_wd_r <= ovl_wd_nxt;
      rgn_wd_r <= rgn_wd_nxt;
      rgn_seen_r <= rgn_seen_nxt;
      clr_d_r  <= clr_lvl;
      cond_d_r <= cond;
      limit_r  <= limit_nxt;
      code_r   <= code_nxt;
      summ_r   <= summ_nxt;
      ack_r    <= ack_nxt;
      dat_r    <= dat_nxt;
    end
  end

  assign fault_code_bit_a_o  = code_r[2];
  assign fault_code_bit_b_o  = code_r[1];
  assign fault_code_bit_c_o  = code_r[0];
  assign fault_summary_out_o = summ_r;
  assign wb_ack_o            = ack_r;
  assign wb_dat_o            = dat_r;

  // Checks on the latch and the code outputs.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic alarm_st;
  assign alarm_st = (state_r == fce_pkg::FCE_ALARM);

  summary_level_a: assert property (
    summ_r == !alarm_st) else $error("summary does not follow alarm state");
  enc_param_a: assert property (
    !alarm_st && enc_q |=> alarm_st && idx_r == 4'h0 && !summ_r)
    else $error("encoder parameter fault not latched");
  turn_code_a: assert property (
    alarm_st && idx_r == fce_pkg::S_TURNS |-> code_r == 3'h5 && !summ_r)
    else $error("multi-turn code wrong");
  pos_err_a: assert property (
    !alarm_st && pos_err_count_i > limit_r && cond[2:0] == 3'h0
    |=> alarm_st && idx_r == 4'h3 && code_r == 3'h6)
    else $error("position overflow not shown");
  option_code_a: assert property (
    alarm_st && idx_r == fce_pkg::S_OPTION |-> code_r == 3'h3 && !summ_r)
    else $error("option code wrong");
  phase_code_a: assert property (
    alarm_st && idx_r == fce_pkg::S_PHASE |-> code_r == 3'h2 && !summ_r)
    else $error("open phase code wrong");
  ovl_order_a: assert property (
    $rose(alarm_st) && idx_r == fce_pkg::S_OVL |-> $past(code_r) == 3'h4)
    else $error("overload alarm without warning");
  regen_order_a: assert property (
    $rose(alarm_st) && idx_r == fce_pkg::S_REGEN |->
    $past(code_r) == 3'h2 || $past(code_r, 2) == 3'h2)
    else $error("regen alarm without warning");
  nonreset_hold_a: assert property (
    alarm_st && fce_pkg::NONRST[idx_r] |=> alarm_st && $stable(idx_r))
    else $error("non-resettable alarm cleared");
  clear_idle_a: assert property (
    alarm_st && clr_edge && !fce_pkg::NONRST[idx_r] && !(|alarms)
    |=> summ_r && !alarm_st &&
        (code_r == fce_pkg::CODE_NONE || code_r == fce_pkg::CODE_OVLW ||
         code_r == fce_pkg::CODE_RGNW))
    else $error("clear did not release outputs");
  first_hold_a: assert property (
    alarm_st && !clr_edge |=> alarm_st && $stable(idx_r) && $stable(code_r))
    else $error("latched code changed");
  ovl_warn_a: assert property (
    !alarm_st && ovl_wd_r |-> code_r == 3'h4 && summ_r)
    else $error("overload warning code wrong");
  regen_warn_a: assert property (
    !alarm_st && rgn_wd_r && !ovl_wd_r |-> code_r == 3'h2 && summ_r)
    else $error("regen warning code wrong");
  idle_code_a: assert property (
    !alarm_st && !ovl_wd_r && !rgn_wd_r |-> code_r == 3'h0 && summ_r)
    else $error("idle code not all off");

  cover_ovl_seq: cover property (code_r == 3'h4 ##[1:50] code_r == 3'h7);
  cover_clear: cover property (alarm_st ##1 !alarm_st);
  cover_irq: cover property ($rose(irq_o));
  // The regen path is covered apart, as it may wait behind the overload warning.
  cover_regen_seq: cover property (code_r == 3'h2 ##[1:50] code_r == 3'h1);

endmodule // fce_encoder

/* testbench/fce_host_model.sv */
// Host controller model: watches the summary output and pulses the clear line.
// Assumes the clear line idles high through a pull-up and is pulled low to clear.
`timescale 1ns/1ps
module fce_host_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic clear_req_i,
  input  wire logic summary_i,
  output logic      fault_clear_in_n_o,
  output logic      alarm_seen_o
);
  logic [2:0] hold_r;
  logic [2:0] hold_nxt;

  always_comb
  begin
    hold_nxt = hold_r;
    if (clear_req_i)
      hold_nxt = 3'h6;
    else if (hold_r != 3'h0)
      hold_nxt = hold_r - 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_r <= 3'h0;
    else
      hold_r <= hold_nxt;
  end

  assign alarm_seen_o       = ~summary_i;
  // The pulse outlasts the input synchroniser, so a single request is enough.
  assign fault_clear_in_n_o = (hold_r == 3'h0);
endmodule // fce_host_model

/* testbench/fce_encoder_tb.sv */
// Testbench of the fault code output encoder: bus tasks and alarm scenarios.
// Assumes the host model drives the clear line and a 25 MHz clock.
`timescale 1ns/1ps
module fce_encoder_tb;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        cyc     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wd      = 32'h0;
  logic [3:0]  sel     = 4'hf;
  logic [8:0]  cause   = 9'h000;
  logic [31:0] cnt     = 32'h0;
  logic        clr_req = 1'b0;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic        ack;
  logic        clr_n;
  logic        ca;
  logic        cb;
  logic        cc;
  logic        summ;
  logic        irq;
  int          bad_count = 0;
  int          n_tests   = 0;
  int          cycles    = 0;

  always #20 clk_i = ~clk_i;

  fce_encoder dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .cause_enc_param_i(cause[0]), .cause_echo_i(cause[1]), .cause_turn_limit_i(cause[2]),
    .cause_option_i(cause[3]), .cause_open_phase_i(cause[4]),
    .cause_ovl_warn_i(cause[5]), .cause_ovl_alarm_i(cause[6]),
    .cause_regen_warn_i(cause[7]), .cause_regen_alarm_i(cause[8]),
    .pos_err_count_i(cnt), .fault_clear_in_n_i(clr_n), .fault_code_bit_a_o(ca),
    .fault_code_bit_b_o(cb), .fault_code_bit_c_o(cc), .fault_summary_out_o(summ),
    .irq_o(irq));

  fce_host_model host (
    .clk_i(clk_i), .rst_i(rst_i), .clear_req_i(clr_req), .summary_i(summ),
    .fault_clear_in_n_o(clr_n), .alarm_seen_o());

  task automatic end_of_test();
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected nibble is {a, b, c, summary}.
  task automatic outs(input logic [3:0] e);
    chk(32'({ca, cb, cc, summ}), 32'(e));
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rdat = rd;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask

  // Covers the synchroniser, the latch and the output register.
  task automatic raise(input logic [8:0] c);
    cause <= c;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic clear();
    @(posedge clk_i);
    clr_req <= 1'b1;
    @(posedge clk_i);
    clr_req <= 1'b0;
    repeat (14) @(posedge clk_i);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  logic [8:0] tc [2] = '{9'h004, 9'h010};
  logic [3:0] te [2] = '{4'ha, 4'h4};
  logic [8:0] nr [2] = '{9'h001, 9'h002};

  initial
  begin
    do_reset();
    outs(4'h1);
    wb(1'b0, fce_pkg::ADR_LIMIT, 32'h0);
    chk(rdat, 32'h0000_0400);
    wb(1'b1, 8'h10, 32'hffff_ffff);
    wb(1'b0, 8'h10, 32'h0);
    chk(rdat, 32'h0);
    sel <= 4'h2;
    wb(1'b1, fce_pkg::ADR_LIMIT, 32'hffff_ff00);
    sel <= 4'hf;
    wb(1'b0, fce_pkg::ADR_LIMIT, 32'h0);
    chk(rdat, 32'h0000_ff00);
    wb(1'b1, fce_pkg::ADR_MASK, 32'h10);
    wb(1'b0, fce_pkg::ADR_MASK, 32'h0);
    chk(rdat, 32'h10);
    raise(9'h008);
    outs(4'h6);
    chk(32'(irq), 32'h1);
    wb(1'b0, fce_pkg::ADR_STATUS, 32'h0);
    chk(rdat, 32'h10);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    raise(9'h00c);
    outs(4'h6);
    raise(9'h000);
    clear();
    outs(4'h1);
    for (int i = 0; i < 2; i++)
    begin
      raise(tc[i]);
      outs(te[i]);
      chk(32'(irq), 32'h0);
      clear();
      outs(te[i]);
      raise(9'h000);
      clear();
      outs(4'h1);
    end
    raise(9'h014);
    outs(4'ha);
    wb(1'b0, fce_pkg::ADR_STATE, 32'h0);
    chk(rdat, 32'h0000_012a);
    raise(9'h000);
    clear();
    wb(1'b1, fce_pkg::ADR_LIMIT, 32'h10);
    cnt <= 32'h10;
    repeat (4) @(posedge clk_i);
    outs(4'h1);
    cnt <= 32'h11;
    repeat (4) @(posedge clk_i);
    outs(4'hc);
    cnt <= 32'h0;
    clear();
    outs(4'h1);
    raise(9'h020);
    outs(4'h9);
    raise(9'h060);
    outs(4'he);
    raise(9'h000);
    clear();
    raise(9'h080);
    outs(4'h5);
    raise(9'h180);
    outs(4'h2);
    raise(9'h000);
    clear();
    outs(4'h1);
    for (int i = 0; i < 2; i++)
    begin
      raise(nr[i]);
      outs(4'ha);
      raise(9'h000);
      clear();
      outs(4'ha);
      do_reset();
      outs(4'h1);
    end
    end_of_test();
  end
endmodule // fce_encoder_tb
